// ### tb.sv
// self-checking bench of the timer block: registers, counter, compares, flags, periodic timeouts
// assumes an apb slave that may stretch access; special mode raised only at the end
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, special_mode, cc_irq, ovf_irq, per_irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rel;
  logic [15:0] cv1, cv2, cv3, cv4, cv5, c0, c1, c2;
  logic [3:0] capture_event, compare_pin, compare_pin_en;
  int fail_count, samples_checked, t0, t1, t2;
  // write flag, address, data written or expected
  logic [23:0] rows [15] = '{24'h1_014_31, 24'h0_014_31, 24'h1_014_fe, 24'h0_014_f1, 24'h1_008_e4,
    24'h0_008_e4, 24'h1_00c_5a, 24'h0_00c_5a, 24'h1_01c_ff, 24'h0_01c_ff, 24'h1_000_ff, 24'h0_000_00,
    24'h0_018_00, 24'h0_020_00, 24'h0_010_00};

  tcf_timer tcf_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .compare_value_1(cv1), .compare_value_2(cv2), .compare_value_3(cv3),
    .compare_value_4(cv4), .compare_value_5(cv5), .capture_event(capture_event), .compare_pin(compare_pin),
    .compare_pin_en(compare_pin_en), .capture_compare_irq(cc_irq), .overflow_irq(ovf_irq),
    .periodic_irq(per_irq));

  // ------------------------------------------------------------
  // clock, edge count since release, helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // reference time base; edge k after release reads k
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) rel <= 32'h0;
    else rel <= rel + 32'h1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // leaves the request up so a following call runs back to back
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, {24'h0, x});
  endtask
  // coherent two-byte read, stamped at the high-byte setup
  task automatic rd_cnt(output logic [15:0] c, output int t);
    t = rel;
    apb(1'b0, 12'h000, 32'h0);
    c[15:8] = q[7:0];
    apb(1'b0, 12'h004, 32'h0);
    c[7:0] = q[7:0];
    idle();
  endtask
  // every compare value set 40 counts ahead, then the match is let pass
  task automatic match();
    rd_cnt(c0, t0);
    {cv1, cv2, cv3, cv4, cv5} <= {5{c0 + 16'h0028}};
    repeat (60) @(posedge pclk);
  endtask
  // polled off the edge so the flag update has landed
  task automatic wait_irq(input logic ovf);
    int n;
    n = 0;
    while ((ovf ? ovf_irq : per_irq) !== 1'b1 && n < 70000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 70000) fail_count++;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    conclude();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, special_mode} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    capture_event = 4'h0;
    {cv1, cv2, cv3, cv4, cv5} = {5{16'hffff}};
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i][20], rows[i][19:8], {24'h0, rows[i][7:0]});
      if (rows[i][20] == 1'b0) chk(q, {24'h0, rows[i][7:0]});
      if (rows[i][20] == 1'b0) chk(e, rows[i][19:8] == 12'h020);
    end
    idle();
    rd_cnt(c1, t1);
    repeat (199) @(posedge pclk);
    rd_cnt(c2, t2);
    chk(c2 - c1, (t2 - t1) / 4);
    // second reset: prescale window missed, count runs at full rate
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (70) @(posedge pclk);
    wr(12'h014, 8'hc2);
    rd(12'h014, 8'hc0);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    c1 = q[15:0];
    apb(1'b0, 12'h004, 32'h0);
    chk(q, {24'h0, c1[7:0] + 8'h04});
    wr(12'h008, 8'he5);
    wr(12'h00c, 8'h08);
    idle();
    match();
    chk(compare_pin, 4'hd);
    chk(compare_pin_en, 4'hf);
    rd(12'h010, 8'hf8);
    chk(cc_irq, 1'b1);
    idle();
    match();
    chk(compare_pin, 4'h1);
    wr(12'h010, 8'h00);
    rd(12'h010, 8'hf8);
    wr(12'h010, 8'hff);
    rd(12'h010, 8'h00);
    // capture pulse lands on the clearing write's access edge
    fork
      wr(12'h010, 8'h01);
      begin
        @(posedge pclk);
        capture_event <= 4'h1;
        @(posedge pclk);
        capture_event <= 4'h0;
      end
    join
    rd(12'h010, 8'h01);
    wr(12'h010, 8'h01);
    wr(12'h01c, 8'h04);
    idle();
    match();
    chk(compare_pin, 4'h5);
    chk(compare_pin_en, 4'h7);
    rd(12'h010, 8'hf0);
    idle();
    capture_event <= 4'hb;
    @(posedge pclk);
    capture_event <= 4'h0;
    @(posedge pclk);
    rd(12'h010, 8'hfb);
    chk(cc_irq, 1'b1);
    wr(12'h00c, 8'h04);
    idle();
    chk(cc_irq, 1'b0);
    capture_event <= 4'h4;
    @(posedge pclk);
    capture_event <= 4'h0;
    @(posedge pclk);
    chk(cc_irq, 1'b1);
    wait_irq(1'b0);
    chk(rel, 32'h2000);
    @(posedge pclk);
    wr(12'h018, 8'hbf);
    rd(12'h018, 8'h40);
    wr(12'h018, 8'h40);
    idle();
    chk(per_irq, 1'b0);
    wait_irq(1'b0);
    chk(rel, 32'h4000);
    @(posedge pclk);
    wr(12'h014, 8'h80);
    rd(12'h018, 8'h40);
    chk(per_irq, 1'b0);
    wr(12'h018, 8'h40);
    wr(12'h014, 8'hc0);
    wr(12'h01c, 8'h05);
    idle();
    wait_irq(1'b0);
    chk(rel, 32'h8000);
    wait_irq(1'b1);
    chk(rel, 32'h10000);
    @(posedge pclk);
    rd(12'h018, 8'hc0);
    // special mode: prescale writable long after the window, twice
    special_mode <= 1'b1;
    wr(12'h014, 8'hc3);
    rd(12'h014, 8'hc3);
    wr(12'h014, 8'hc1);
    rd(12'h014, 8'hc1);
    idle();
    conclude();
  end
endmodule
`default_nettype wire

// ### tcf_map.svh
// register offsets, field positions, reset values and timing counts of the timer block
// assumes a 32-bit apb slave with one byte register per aligned word
`ifndef TCF_MAP_SVH
`define TCF_MAP_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define TCF_OFF_COUNT_HI 12'h000
`define TCF_OFF_COUNT_LO 12'h004
`define TCF_OFF_PIN_CTRL 12'h008
`define TCF_OFF_EN1 12'h00c
`define TCF_OFF_FLG1 12'h010
`define TCF_OFF_EN2 12'h014
`define TCF_OFF_FLG2 12'h018
`define TCF_OFF_ACC_CTRL 12'h01c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCF_F1_CH45 3
`define TCF_F2_OVF 7
`define TCF_F2_PER 6
`define TCF_ACC_SEL45 2
`define TCF_EN2_IMPL_MASK 8'hf3
`define TCF_FLG2_IMPL_MASK 8'hf0

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define TCF_RST_BYTE 8'h00
`define TCF_RST_PINS 4'h0
`define TCF_PR_WINDOW_CYC 7'd64
`define TCF_PER_BASE_LOG2 13

`endif

// ### tcf_pkg.sv
// types shared by the timer block
// assumes nothing beyond the map header
package tcf_pkg;
  // action of one compare pin on a match
  typedef enum logic [1:0] {
    tcf_act_off,
    tcf_act_toggle,
    tcf_act_low,
    tcf_act_high
  } tcf_pin_act_t;
endpackage

// ### tcf_timer.sv
// control, status and periodic interrupt logic of the main timer
// assumes compare values and capture events come from logic on pclk
//
// Implementation choices: the register offsets and the APB interface to the registers.
`include "tcf_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tcf_timer
  import tcf_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic [CNT_W-1:0] compare_value_1,
  input wire logic [CNT_W-1:0] compare_value_2,
  input wire logic [CNT_W-1:0] compare_value_3,
  input wire logic [CNT_W-1:0] compare_value_4,
  input wire logic [CNT_W-1:0] compare_value_5,
  input wire logic [3:0] capture_event,
  output logic [3:0] compare_pin,
  output logic [3:0] compare_pin_en,
  output logic capture_compare_irq,
  output logic overflow_irq,
  output logic periodic_irq
);

  // overview: a prescaled 16-bit counter feeds five comparators
  // and the overflow flag; a separate free-running divider times
  // the periodic interrupt, untouched by the prescaler
  // flags are set by hardware and cleared by writing ones
  // every register is a byte in the low lane of a word
  // nothing here stalls the bus: pready is tied high

  // ------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------
  // counter state; four prescaler bits cover the largest factor
  logic [CNT_W-1:0] free_running_count_r;
  logic [3:0] presc_cnt_r;
  logic cnt_tick;
  logic cnt_new_r;
  logic [7:0] count_lo_buf_r;
  logic lo_buf_valid_r;
  // software-visible byte registers
  logic [7:0] compare_pin_action_ctrl_r;
  logic [7:0] capture_compare_irq_enable_r;
  logic [7:0] capture_compare_flags_r;
  logic [7:0] overflow_periodic_irq_enable_r;
  logic [7:0] overflow_periodic_flags_r;
  logic [7:0] accumulator_rate_control_r;
  // one-shot prescale window and periodic divider
  logic [6:0] pr_window_r;
  logic pr_locked_r;
  logic [15:0] per_div_r;
  logic per_timeout;
  // pin drivers and event vectors
  logic [3:0] compare_pin_r;
  logic [3:0] compare_pin_en_r;
  logic [4:0] match;
  logic [7:0] flg1_set;
  logic [7:0] flg2_set;
  // bus phase decode and read path
  logic setup_ph;
  logic wr_done;
  logic rd_done;
  logic [7:0] wbyte;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic sel45;

  // every access phase completes on its first edge,
  // so writes land on that edge
  assign setup_ph = psel & ~penable;
  assign wr_done = psel & penable & pwrite;
  assign rd_done = psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign sel45 = accumulator_rate_control_r[`TCF_ACC_SEL45];

  // returns the last prescaler state of a period, so the counter
  // advances once every (returned value + 1) bus cycles
  // prescale factor from the select code
  function automatic logic [3:0] presc_last(input logic [1:0] code);
    unique case (code)
      2'b00: presc_last = 4'h0;
      2'b01: presc_last = 4'h3;
      2'b10: presc_last = 4'h7;
      2'b11: presc_last = 4'hf;
    endcase
  endfunction

  // the lower 13 to 16 divider bits all ones mark a period end;
  // the rate code only picks which bit of one chain is tapped,
  // so no reload value is needed for any rate
  // periodic timeout when the low bits of the divider are all ones
  function automatic logic per_hit(input logic [15:0] div, input logic [1:0] rate);
    logic [15:0] mask;
    mask = 16'h0000;
    mask = (16'h0001 << (`TCF_PER_BASE_LOG2 + int'(rate))) - 16'h0001;
    per_hit = (div & mask) == mask;
  endfunction

  // ------------------------------------------------------------
  // prescaler and free-running counter
  // ------------------------------------------------------------
  // one tick per prescale period; always high for a factor of 1
  assign cnt_tick = presc_cnt_r == presc_last(overflow_periodic_irq_enable_r[1:0]);

  // prescaler stage; a code change mid-run only resizes the current period
  // a stage left above a smaller new limit wraps at once instead
  // of running through all sixteen states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_r <= 4'h0;
    end else if (cnt_tick || presc_cnt_r > presc_last(overflow_periodic_irq_enable_r[1:0])) begin
      presc_cnt_r <= 4'h0;
    end else begin
      presc_cnt_r <= presc_cnt_r + 4'h1;
    end
  end

  // counter itself, read-only to software
  // cnt_new_r marks the first cycle of each count value; it is set
  // in reset because the count already holds its first value 0
  // wraps from all ones to zero with no stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_running_count_r <= '0;
      cnt_new_r <= 1'b1;
    end else begin
      cnt_new_r <= cnt_tick;
      if (cnt_tick) begin
        free_running_count_r <= free_running_count_r + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // compare matches and pin actions
  // ------------------------------------------------------------
  // all five comparators run in parallel on every bus cycle; the
  // compare values are used as they stand, with no write inhibit
  // only the first cycle of each count value matches, so a slow
  // prescale does not toggle a pin several times on one value
  always_comb begin
    match[0] = cnt_new_r && free_running_count_r == compare_value_1;
    match[1] = cnt_new_r && free_running_count_r == compare_value_2;
    match[2] = cnt_new_r && free_running_count_r == compare_value_3;
    match[3] = cnt_new_r && free_running_count_r == compare_value_4;
    match[4] = cnt_new_r && free_running_count_r == compare_value_5;
  end

  // pin channels two to five; control pairs run from bit 7 down
  // the pin enable follows the action code one cycle after a write
  // a disconnected pin keeps its last level for a later reconnect
  // channel five is held off while the shared slot captures
  // toggle reads the pin flop, so it flips the level the pin last drove
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin_r <= `TCF_RST_PINS;
      compare_pin_en_r <= `TCF_RST_PINS;
    end else begin
      for (int i = 0; i < 4; i++) begin
        tcf_pin_act_t act;
        logic fire;
        act = tcf_pin_act_t'(compare_pin_action_ctrl_r[7-2*i -: 2]);
        fire = match[i+1] && (i != 3 || !sel45);
        compare_pin_en_r[i] <= (act != tcf_act_off) && (i != 3 || !sel45);
        if (fire) begin
          unique case (act)
            tcf_act_off: compare_pin_r[i] <= compare_pin_r[i];
            tcf_act_toggle: compare_pin_r[i] <= ~compare_pin_r[i];
            tcf_act_low: compare_pin_r[i] <= 1'b0;
            tcf_act_high: compare_pin_r[i] <= 1'b1;
          endcase
        end
      end
    end
  end

  // pins straight from their flops
  assign compare_pin = compare_pin_r;
  assign compare_pin_en = compare_pin_en_r;

  // ------------------------------------------------------------
  // periodic divider
  // ------------------------------------------------------------
  // timeout seen combinationally, flag set on the following edge
  assign per_timeout = per_hit(per_div_r, accumulator_rate_control_r[1:0]);

  // never stopped or reloaded by software, so periods run timeout to timeout
  // it also runs while the periodic enable is low, so turning the
  // enable on never shortens or stretches the period in progress
  // reset clears it, so the first period is a full one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_div_r <= 16'h0000;
    end else begin
      per_div_r <= per_div_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // flag set events
  // ------------------------------------------------------------
  // one set vector per flag register; bit order follows the enables
  // so each enable bit gates the flag in the same position
  // capture events arrive as one-cycle pulses, edge already chosen
  always_comb begin
    flg1_set = 8'h00;
    flg1_set[7:4] = {match[0], match[1], match[2], match[3]};
    flg1_set[`TCF_F1_CH45] = sel45 ? capture_event[3] : match[4];
    flg1_set[2:0] = capture_event[2:0];
    flg2_set = 8'h00;
    flg2_set[`TCF_F2_OVF] = cnt_tick && (&free_running_count_r);
    flg2_set[`TCF_F2_PER] = per_timeout;
  end

  // first flag register; set beats a same-cycle clear
  // software clears with ones; zeros written leave a flag alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_compare_flags_r <= `TCF_RST_BYTE;
    end else begin
      logic [7:0] clr;
      clr = (wr_done && paddr == `TCF_OFF_FLG1) ? wbyte : 8'h00;
      capture_compare_flags_r <= (capture_compare_flags_r & ~clr) | flg1_set;
    end
  end

  // second flag register; accumulator flags live outside this block
  // only the overflow and periodic bits are kept; the rest read 0,
  // and the read mux also masks the spare low nibble off with f0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_periodic_flags_r <= `TCF_RST_BYTE;
    end else begin
      logic [7:0] clr;
      clr = (wr_done && paddr == `TCF_OFF_FLG2) ? wbyte : 8'h00;
      overflow_periodic_flags_r <= ((overflow_periodic_flags_r & ~clr) | flg2_set) & 8'hc0;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // plain read/write control bytes; writes land on the access edge
  // pin action, enable one and accumulator control carry no locks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin_action_ctrl_r <= `TCF_RST_BYTE;
      capture_compare_irq_enable_r <= `TCF_RST_BYTE;
      accumulator_rate_control_r <= `TCF_RST_BYTE;
    end else if (wr_done) begin
      if (paddr == `TCF_OFF_PIN_CTRL) begin
        compare_pin_action_ctrl_r <= wbyte;
      end
      if (paddr == `TCF_OFF_EN1) begin
        capture_compare_irq_enable_r <= wbyte;
      end
      if (paddr == `TCF_OFF_ACC_CTRL) begin
        accumulator_rate_control_r <= wbyte;
      end
    end
  end

  // window counter for the one-shot prescale write
  // it stops at the window size so it never wraps and reopens it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_window_r <= 7'd0;
    end else if (pr_window_r != `TCF_PR_WINDOW_CYC) begin
      pr_window_r <= pr_window_r + 7'd1;
    end
  end

  // enables always writable; prescale select only once inside the window
  // any write inside the window uses up the one-shot, even one that
  // rewrites the reset code; special mode lifts both limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_periodic_irq_enable_r <= `TCF_RST_BYTE;
      pr_locked_r <= 1'b0;
    end else if (wr_done && paddr == `TCF_OFF_EN2) begin
      overflow_periodic_irq_enable_r[7:4] <= wbyte[7:4];
      if (special_mode || (!pr_locked_r && pr_window_r != `TCF_PR_WINDOW_CYC)) begin
        overflow_periodic_irq_enable_r[1:0] <= wbyte[1:0];
        pr_locked_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt requests
  // ------------------------------------------------------------
  // requests are levels: they stay up until software clears the
  // flag or the enable; no edge of them is stored here
  // three separate requests so a controller can rank them
  assign capture_compare_irq = |(capture_compare_flags_r & capture_compare_irq_enable_r);
  assign overflow_irq = overflow_periodic_flags_r[`TCF_F2_OVF] &
                        overflow_periodic_irq_enable_r[`TCF_F2_OVF];
  assign periodic_irq = overflow_periodic_flags_r[`TCF_F2_PER] &
                        overflow_periodic_irq_enable_r[`TCF_F2_PER];

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  // reads have no side effect except the low-byte buffer below
  // unmapped and misaligned offsets fall through to the error answer
  // read mux of the byte registers
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (paddr)
      `TCF_OFF_COUNT_HI: rd_byte = free_running_count_r[15:8];
      `TCF_OFF_COUNT_LO: rd_byte = lo_buf_valid_r ? count_lo_buf_r : free_running_count_r[7:0];
      `TCF_OFF_PIN_CTRL: rd_byte = compare_pin_action_ctrl_r;
      `TCF_OFF_EN1: rd_byte = capture_compare_irq_enable_r;
      `TCF_OFF_FLG1: rd_byte = capture_compare_flags_r;
      `TCF_OFF_EN2: rd_byte = overflow_periodic_irq_enable_r & `TCF_EN2_IMPL_MASK;
      `TCF_OFF_FLG2: rd_byte = overflow_periodic_flags_r & `TCF_FLG2_IMPL_MASK;
      `TCF_OFF_ACC_CTRL: rd_byte = accumulator_rate_control_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // answer formed in setup, so data comes from flops with no wait state
  // the trade: the byte seen is the state at the setup edge, which
  // is also the snapshot time of a coherent counter read
  // write answers carry zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_r <= ~rd_hit;
    end
  end

  // low byte buffer; valid only for the access straight after a high read
  // an idle gap keeps the buffer; any other access drops it, so a
  // lone low-byte read always sees the live count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_lo_buf_r <= 8'h00;
      lo_buf_valid_r <= 1'b0;
    end else begin
      if (setup_ph && !pwrite && paddr == `TCF_OFF_COUNT_HI) begin
        count_lo_buf_r <= free_running_count_r[7:0];
      end
      if (rd_done && paddr == `TCF_OFF_COUNT_HI) begin
        lo_buf_valid_r <= 1'b1;
      end else if (psel && penable) begin
        lo_buf_valid_r <= 1'b0;
      end
    end
  end

  // outputs from flops; pready constant, error gated to access
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & pslverr_r;

endmodule

`default_nettype wire

// ### tcf_timer_asserts.sv
// concurrent checks of the timer block, bound onto its top module
// assumes an apb master that holds each request until pready
`include "tcf_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tcf_timer_asserts
  import tcf_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic special_mode,
  input wire logic [CNT_W-1:0] compare_value_1,
  input wire logic [CNT_W-1:0] compare_value_2,
  input wire logic [CNT_W-1:0] compare_value_3,
  input wire logic [CNT_W-1:0] compare_value_4,
  input wire logic [CNT_W-1:0] compare_value_5,
  input wire logic [3:0] capture_event,
  input wire logic [3:0] compare_pin,
  input wire logic [3:0] compare_pin_en,
  input wire logic capture_compare_irq,
  input wire logic overflow_irq,
  input wire logic periodic_irq
);
  // ------------------------------------------------------------
  // shadow of the control bytes
  // ------------------------------------------------------------
  logic [7:0] pin_s, en1_s, en2_s, acc_s;
  logic [3:0] exp_en;
  // follows apb writes; enable bits of mask two are never locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pin_s, en1_s, en2_s, acc_s} <= 32'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == `TCF_OFF_PIN_CTRL) pin_s <= pwdata[7:0];
      if (paddr == `TCF_OFF_EN1) en1_s <= pwdata[7:0];
      if (paddr == `TCF_OFF_EN2) en2_s <= pwdata[7:0];
      if (paddr == `TCF_OFF_ACC_CTRL) acc_s <= pwdata[7:0];
    end
  end
  // channel five drops out while the shared slot captures
  assign exp_en = {pin_s[1:0] != 2'h0 && !acc_s[2], pin_s[3:2] != 2'h0, pin_s[5:4] != 2'h0, pin_s[7:6] != 2'h0};

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_acc;
    psel && penable;
  endsequence
  sequence rd_of(logic [11:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  pready_high_a: assert property (pready)
    else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside access");
  err_unmapped_a: assert property (apb_acc ##0 (paddr > 12'h01c || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  en2_unimpl_a: assert property (rd_of(`TCF_OFF_EN2) |-> prdata[3:2] == 2'h0)
    else $error("mask two spare bits not zero");
  flg2_unimpl_a: assert property (rd_of(`TCF_OFF_FLG2) |-> prdata[3:0] == 4'h0)
    else $error("flag two spare bits not zero");
  pin_en_low_a: assert property ($stable(exp_en) |-> compare_pin_en[2:0] == exp_en[2:0])
    else $error("pin enable disagrees with action code");
  pin_en_five_a: assert property ($stable(exp_en) |-> compare_pin_en[3] == exp_en[3])
    else $error("channel five pin enable wrong");
  cc_irq_gate_a: assert property (capture_compare_irq |-> en1_s != 8'h00)
    else $error("capture compare request without enable");
  ovf_irq_gate_a: assert property (overflow_irq |-> en2_s[7])
    else $error("overflow request without enable");
  per_irq_gate_a: assert property (periodic_irq |-> en2_s[6])
    else $error("periodic request without enable");
endmodule

bind tcf_timer tcf_timer_asserts #(.CNT_W(CNT_W)) tcf_timer_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
  .compare_value_1(compare_value_1), .compare_value_2(compare_value_2), .compare_value_3(compare_value_3),
  .compare_value_4(compare_value_4), .compare_value_5(compare_value_5), .capture_event(capture_event),
  .compare_pin(compare_pin), .compare_pin_en(compare_pin_en), .capture_compare_irq(capture_compare_irq),
  .overflow_irq(overflow_irq), .periodic_irq(periodic_irq)
);
`default_nettype wire
